// >>> core/gpio_f_port.sv
// eight pin port shared with converter, comparators and serial select
`default_nettype none

// Summary of operation
// [R1] A direction bit of 1 turns the pin driver off so the pin is an input.
// [R2] A direction bit of 0 drives the pin from its latch bit unless an alternate function owns it.
// [R3] Reading the latch register returns the stored latch, not the pin level.
// [R4] Reading the pin register returns sampled pins, writing it loads the latch.
// [R5] The port is eight bits wide with a separate direction bit per pin.
// [R6] With outputs enabled and direction 0, comparator two drives pin 1 and comparator one drives pin 2.
// [R7] On pins 0 to 6 an analog selection blocks the digital input but not the output.
// [R8] After reset pins 0 to 6 are analog inputs and read back as zero.
// [R9] Pins 0 to 6 are converter channels 5 to 11 and pins 3 to 6 feed the comparators.
// [R10] An enabled reference output on pin 5 blocks both its digital input and output.
// [R11] Pin 7 has no analog use and, as an input, feeds the serial slave select and the read.
// [R12] Pins 3 to 6 read no digital input while the comparators are active.
// [R13] Software should clear the latch, turn comparators and analog off, then set directions.
// [R14] Pin levels pass a synchroniser before they reach the pin register.
module gpio_f_port #(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [ADDR_W-1:0]       wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // port pins
  input  wire logic [7:0]              pin_i,
  output logic      [7:0]              pin_o,
  output logic      [7:0]              pin_oe_n_o,
  // comparator outputs from the comparator block
  input  wire logic                    comparator_one_output_i,
  input  wire logic                    comparator_two_output_i,
  // shared function controls
  output logic [11:0]                  converter_channel_enable_o,
  output logic [3:0]                   comparator_input_enable_o,
  output logic                         comparator_reference_output_o,
  output logic                         slave_select_o
);

  // elaboration check
  if (ADDR_W < 5)
  begin : g_bad_addr_w
    $error("gpio_f_port: ADDR_W must be at least 5");
  end

  // register state
  logic [7:0]            dir_q;
  logic [7:0]            dir_d;
  logic [7:0]            latch_q;
  logic [7:0]            latch_d;
  gpio_f_pkg::ctrl_s     ctrl_q;
  gpio_f_pkg::ctrl_s     ctrl_d;
  logic                  ack_q;
  logic [31:0]           dat_q;

  // synchroniser state
  logic [7:0]            sync1_q;
  logic [7:0]            sync2_q;
  logic [7:0]            sync3_q;
  logic [7:0]            level_q;
  logic [7:0]            level_d;

  // output flops
  logic [7:0]            pin_out_q;
  logic [7:0]            pin_oe_n_q;
  logic [11:0]           chan_en_q;
  logic [3:0]            cmp_in_q;
  logic                  ref_q;
  logic                  ss_q;

  // per pin combinational results
  logic [7:0]            dig_in_en;
  logic [7:0]            drive_en;
  logic [7:0]            pin_out_d;
  logic [7:0]            analog_pin;
  logic [7:0]            pin_read;

  // bus decode
  wire                   req      = wb_cyc_i & wb_stb_i & ~ack_q;
  wire                   wr       = req & wb_we_i;
  wire [4:0]             word_adr = {wb_adr_i[4:2], 2'b00};
  wire                   hit_dir  = (word_adr == gpio_f_pkg::DIR_OFF);
  wire                   hit_pin  = (word_adr == gpio_f_pkg::PIN_OFF);
  wire                   hit_lat  = (word_adr == gpio_f_pkg::LATCH_OFF);
  wire                   hit_ctl  = (word_adr == gpio_f_pkg::CTRL_OFF);
  wire                   hit_sta  = (word_adr == gpio_f_pkg::STAT_OFF);
  wire                   hi_ok    = (wb_adr_i[ADDR_W-1:5] == '0);
  wire                   lane0    = wb_sel_i[0];
  wire                   lane1    = wb_sel_i[1];

  // control word as seen on the bus
  wire [31:0]            ctrl_word = {21'h000000, ctrl_q.ref_oe,
                                      ctrl_q.cmp_oe, ctrl_q.cmp_act,
                                      1'b0, ctrl_q.analog_sel};
  wire [31:0]            stat_word = {29'h00000000, ss_q,
                                      comparator_two_output_i,
                                      comparator_one_output_i};

  // per pin routing
  genvar gi;
  generate
    for (gi = 0; gi < gpio_f_pkg::PORT_W; gi = gi + 1)
    begin : g_pin
      // [R7] analog blocks input
      if (gi < gpio_f_pkg::ANALOG_PINS)
      begin : g_ana
        assign analog_pin[gi] = ctrl_q.analog_sel[gi];
      end
      else
      begin : g_dig
        // [R11] no analog use
        assign analog_pin[gi] = 1'b0;
      end

      // [R10] reference takes pin
      wire ref_here = (gi == gpio_f_pkg::REF_PIN) && ctrl_q.ref_oe;
      // [R12] comparators hold pins
      wire cmp_here = (gi >= gpio_f_pkg::CMP_LO_PIN) &&
                      (gi <= gpio_f_pkg::CMP_HI_PIN) && ctrl_q.cmp_act;

      assign dig_in_en[gi] = ~analog_pin[gi] & ~ref_here & ~cmp_here;

      // [R1] input when set
      // [R2] output when clear
      assign drive_en[gi] = ~dir_q[gi] & ~ref_here;

      // [R6] comparator outputs override
      if (gi == gpio_f_pkg::COMP_TWO_PIN)
      begin : g_c2
        assign pin_out_d[gi] = ctrl_q.cmp_oe ? comparator_two_output_i
                                             : latch_q[gi];
      end
      else if (gi == gpio_f_pkg::COMP_ONE_PIN)
      begin : g_c1
        assign pin_out_d[gi] = ctrl_q.cmp_oe ? comparator_one_output_i
                                             : latch_q[gi];
      end
      else
      begin : g_lat
        assign pin_out_d[gi] = latch_q[gi];
      end

      // [R14] accept when stages agree
      assign level_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi]
                                                        : level_q[gi];
    end
  endgenerate

  // [R4] pin read path
  // [R8] analog pins read zero
  assign pin_read = level_q & dig_in_en;

  // register writes by byte lane
  // [R5] independent direction bits
  assign dir_d   = (wr & hit_dir & hi_ok & lane0) ? wb_dat_i[7:0] : dir_q;
  // [R4] pin write loads latch
  assign latch_d = (wr & (hit_lat | hit_pin) & hi_ok & lane0)
                   ? wb_dat_i[7:0] : latch_q;

  // control word writes
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr & hit_ctl & hi_ok & lane0)
    begin
      ctrl_d.analog_sel = wb_dat_i[gpio_f_pkg::CTRL_ANALOG_LSB +: 7];
    end
    if (wr & hit_ctl & hi_ok & lane1)
    begin
      ctrl_d.cmp_act = wb_dat_i[gpio_f_pkg::CTRL_CMP_ACT];
      ctrl_d.cmp_oe  = wb_dat_i[gpio_f_pkg::CTRL_CMP_OE];
      ctrl_d.ref_oe  = wb_dat_i[gpio_f_pkg::CTRL_REF_OE];
    end
  end

  // read data select, unmapped reads zero
  wire [31:0] rd_word =
    ~hi_ok  ? 32'h00000000 :
    hit_dir ? {24'h000000, dir_q} :
    hit_pin ? {24'h000000, pin_read} :
    // [R3] latch reads stored value
    hit_lat ? {24'h000000, latch_q} :
    hit_ctl ? ctrl_word :
    hit_sta ? stat_word : 32'h00000000;

  // [R9] channel map for converter
  wire [11:0] chan_en_d = {ctrl_q.analog_sel,
                           {gpio_f_pkg::FIRST_CHANNEL{1'b0}}};

  // register file
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dir_q   <= gpio_f_pkg::DIR_RST;
      latch_q <= gpio_f_pkg::LATCH_RST;
      ctrl_q  <= gpio_f_pkg::CTRL_RST;
    end
    else
    begin
      dir_q   <= dir_d;
      latch_q <= latch_d;
      ctrl_q  <= ctrl_d;
    end
  end

  // bus answer, one cycle after request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= req;
      dat_q <= req ? rd_word : 32'h00000000;
    end
  end

  // [R14] pin synchroniser chain
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      sync3_q <= 8'h00;
      level_q <= 8'h00;
    end
    else
    begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= level_d;
    end
  end

  // pin drive and shared function outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_out_q  <= 8'h00;
      pin_oe_n_q <= 8'hFF;
      chan_en_q  <= 12'h000;
      cmp_in_q   <= 4'h0;
      ref_q      <= 1'b0;
      ss_q       <= 1'b1;
    end
    else
    begin
      pin_out_q  <= pin_out_d;
      pin_oe_n_q <= ~drive_en;
      chan_en_q  <= chan_en_d;
      // [R9] comparator input feed
      cmp_in_q   <= {4{ctrl_q.cmp_act}};
      ref_q      <= ctrl_q.ref_oe;
      // [R11] slave select from input
      ss_q       <= dir_q[gpio_f_pkg::SS_PIN] ?
                    level_q[gpio_f_pkg::SS_PIN] : 1'b1;
    end
  end

  // outputs straight from flops
  assign wb_ack_o                      = ack_q;
  assign wb_dat_o                      = dat_q;
  assign pin_o                         = pin_out_q;
  assign pin_oe_n_o                    = pin_oe_n_q;
  assign converter_channel_enable_o    = chan_en_q;
  assign comparator_input_enable_o     = cmp_in_q;
  assign comparator_reference_output_o = ref_q;
  assign slave_select_o                = ss_q;

endmodule : gpio_f_port
`default_nettype wire

// >>> inc/gpio_f_pkg.sv
// constants and types for the eight pin analog shared port
`default_nettype none
package gpio_f_pkg;

  // port geometry
  localparam int unsigned PORT_W        = 8;
  localparam int unsigned ANALOG_PINS   = 7;
  localparam int unsigned FIRST_CHANNEL = 5;
  localparam int unsigned CHANNELS      = 12;
  localparam int unsigned SYNC_STAGES   = 3;

  // pin positions of shared functions
  localparam int unsigned COMP_TWO_PIN = 1;
  localparam int unsigned COMP_ONE_PIN = 2;
  localparam int unsigned CMP_LO_PIN   = 3;
  localparam int unsigned CMP_HI_PIN   = 6;
  localparam int unsigned REF_PIN      = 5;
  localparam int unsigned SS_PIN       = 7;

  // register byte offsets
  localparam logic [4:0] DIR_OFF   = 5'h00;
  localparam logic [4:0] PIN_OFF   = 5'h04;
  localparam logic [4:0] LATCH_OFF = 5'h08;
  localparam logic [4:0] CTRL_OFF  = 5'h0C;
  localparam logic [4:0] STAT_OFF  = 5'h10;

  // control word field positions
  localparam int unsigned CTRL_ANALOG_LSB = 0;
  localparam int unsigned CTRL_CMP_ACT    = 8;
  localparam int unsigned CTRL_CMP_OE     = 9;
  localparam int unsigned CTRL_REF_OE     = 10;

  // status word field positions
  localparam int unsigned STAT_CMP_ONE = 0;
  localparam int unsigned STAT_CMP_TWO = 1;
  localparam int unsigned STAT_SS      = 2;

  // control word carrier
  typedef struct packed {
    logic       ref_oe;
    logic       cmp_oe;
    logic       cmp_act;
    logic [6:0] analog_sel;
  } ctrl_s;

  // values after reset
  localparam logic [7:0] DIR_RST    = 8'hFF;
  localparam logic [7:0] LATCH_RST  = 8'h00;
  localparam logic [6:0] ANALOG_RST = 7'h7F;
  localparam ctrl_s      CTRL_RST   = '{ref_oe: 1'b0, cmp_oe: 1'b0,
                                        cmp_act: 1'b0,
                                        analog_sel: ANALOG_RST};

endpackage : gpio_f_pkg
`default_nettype wire

// >>> tb/board_pins.sv
// board circuitry resolving each port pin level
`default_nettype none
module board_pins (
  // device drive and board levels
  input  wire logic [7:0] dev_i,
  input  wire logic [7:0] oe_n_i,
  input  wire logic [7:0] board_i,
  // level seen on the pins
  output logic      [7:0] lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // device wins where it drives, else the board level
  assign lvl_o = (~oe_n_i & dev_i) | (oe_n_i & board_i);
endmodule : board_pins
`default_nettype wire

// >>> tb/gpio_f_port_monitor.sv
// assertion checker for the analog shared port
`default_nettype none
module gpio_f_port_monitor (
  // clock, reset, bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // pins and shared functions
  input wire logic [7:0]  pin_i,
  input wire logic [7:0]  pin_o,
  input wire logic [7:0]  pin_oe_n_o,
  input wire logic [11:0] converter_channel_enable_o,
  input wire logic [3:0]  comparator_input_enable_o,
  input wire logic        comparator_reference_output_o,
  input wire logic        slave_select_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // request taken and a steady input on pin 7
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pin7_steady;
    (pin_oe_n_o[7] && $stable(pin_i[7]))[*7];
  endsequence
  property p_ack_answer; s_taken |=> wb_ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("no ack after request");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data outside ack");
  property p_reset_state;
    $fell(rst_i) |-> pin_oe_n_o == 8'hFF && pin_o == 8'h00
      ##[0:1] converter_channel_enable_o == 12'hFE0;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("wrong state after reset");
  property p_chan_low; converter_channel_enable_o[4:0] == 5'h00; endproperty
  a_chan_low: assert property (p_chan_low)
    else $error("unmapped channel enabled");
  property p_cmp_group; comparator_input_enable_o inside {4'h0, 4'hF};
  endproperty
  a_cmp_group: assert property (p_cmp_group)
    else $error("comparator inputs split");
  property p_ref_blocks;
    comparator_reference_output_o && $past(comparator_reference_output_o)
      |-> pin_oe_n_o[5];
  endproperty
  a_ref_blocks: assert property (p_ref_blocks)
    else $error("pin 5 driven under reference");
  property p_ss_idle;
    !pin_oe_n_o[7] && $past(!pin_oe_n_o[7]) |-> slave_select_o;
  endproperty
  a_ss_idle: assert property (p_ss_idle)
    else $error("select active on output pin");
  property p_ss_follow; s_pin7_steady |-> slave_select_o == pin_i[7];
  endproperty
  a_ss_follow: assert property (p_ss_follow)
    else $error("select not following pin 7");
endmodule : gpio_f_port_monitor
bind gpio_f_port gpio_f_port_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pin_o(pin_o),
  .pin_oe_n_o(pin_oe_n_o), .slave_select_o(slave_select_o),
  .converter_channel_enable_o(converter_channel_enable_o),
  .comparator_input_enable_o(comparator_input_enable_o),
  .comparator_reference_output_o(comparator_reference_output_o));
`default_nettype wire

// >>> tb/test_gpio_f_port.sv
// self-checking bench for the analog shared port
`default_nettype none
module test_gpio_f_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, cyc, we, c1, c2, ack, ref_o, ss;
  logic [7:0] adr, board, lvl, pin_o, oe_n;
  logic [3:0] sel, cmp_in;
  logic [31:0] wdat, rdat, dat_o;
  logic [11:0] chan;
  int num_errors, n_compared, dir, lat, ctl, r, drv, ev, lv, msk;
  gpio_f_port #(.ADDR_W(8)) u_gpio_f_port (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .pin_i(lvl), .pin_o(pin_o),
    .pin_oe_n_o(oe_n), .comparator_one_output_i(c1),
    .comparator_two_output_i(c2), .converter_channel_enable_o(chan),
    .comparator_input_enable_o(cmp_in),
    .comparator_reference_output_o(ref_o), .slave_select_o(ss));
  board_pins u_board_pins (.dev_i(pin_o), .oe_n_i(oe_n), .board_i(board),
    .lvl_o(lvl));
  // verdict and end of run
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    for (i = 0; i < 50 && ack !== 1'b1; i++)
      @(posedge clk_i);
    if (i == 50)
    begin
      num_errors++;
      $display("mismatch ack exp 1 got %b", ack);
      final_report();
    end
    rdat = dat_o;
    cyc <= 1'b0;
  endtask : wb
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial
  begin
    {rst_i, cyc, we, c1, c2, adr, wdat, sel} = '0;
    rst_i = 1'b1;
    board = 8'h5A;
    void'($urandom(32'hCAAC7E62));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 8'h00, 0, 4'hF); chk("dir", 32'hFF, rdat);
    wb(0, 8'h04, 0, 4'hF); chk("pins", 32'h0, rdat);
    wb(0, 8'h0C, 0, 4'hF); chk("ctrl", 32'h7F, rdat);
    wb(1, 8'h14, 32'hFF, 4'hF); wb(0, 8'h24, 0, 4'hF);
    chk("unmapped", 32'h0, rdat);
    dir = 'hFF;
    lat = 0;
    ctl = 0;
    wb(1, 8'h08, 0, 4'hF);
    wb(1, 8'h0C, 0, 4'hF);
    repeat (24)
    begin
      r = $urandom;
      wb(1, 8'h00, r & 'hFF, 4'h1);
      dir = r & 'hFF;
      r = $urandom;
      wb(1, r[8] ? 8'h04 : 8'h08, r & 'hFF, {3'h0, r[9]});
      if (r[9]) lat = r & 'hFF;
      r = $urandom;
      wb(1, 8'h0C, r, r[13:10]);
      if (r[10]) ctl = (ctl & 'h700) | (r & 'h7F);
      if (r[11]) ctl = (ctl & 'h7F) | (r & 'h700);
      board <= r[23:16];
      c1 <= r[24];
      c2 <= r[25];
      repeat (8) @(posedge clk_i);
      drv = ~dir & (ctl[10] ? 'hDF : 'hFF);
      ev = ctl[9] ? (lat & 'hF9) | (c2 << 1) | (c1 << 2) : lat;
      lv = ((drv & ev) | (~drv & board)) & 'hFF;
      msk = (ctl & 'h7F) | (ctl[10] ? 'h20 : 0) | (ctl[8] ? 'h78 : 0);
      chk("oe_n", ~drv & 'hFF, oe_n);
      chk("drive", drv & ev, pin_o & drv);
      chk("chan", (ctl & 'h7F) << 5, chan);
      chk("cmp_in", ctl[8] ? 'hF : 0, cmp_in);
      chk("ref", ctl[10], ref_o);
      chk("ss", dir[7] ? lv[7] : 1, ss);
      wb(0, 8'h08, 0, 4'hF); chk("latch", lat, rdat);
      wb(0, 8'h04, 0, 4'hF); chk("pins", lv & ~msk, rdat);
      wb(0, 8'h00, 0, 4'hF); chk("dir", dir, rdat);
      wb(0, 8'h0C, 0, 4'hF); chk("ctrl", ctl, rdat);
      wb(0, 8'h10, 0, 4'hF);
      chk("stat", {(dir[7] ? lv[7] : 1'b1), c2, c1}, rdat);
    end
    final_report();
  end
endmodule : test_gpio_f_port
`default_nettype wire
